// ### adcc_conv_ctrl.v
// Conversion control: registers, start selection, track/convert sequence, result format
// How it works
// - Conversion clock is system clock divided by divider field plus one.
// - Start source is software, timer 0-3 overflow, or external start edge.
// - With software source, writing busy bit one starts a conversion at once.
// - Busy bit stays one throughout conversion, clears when it ends.
// - Busy falling edge sets done flag and raises interrupt when enabled.
// - Result bytes hold the new result before done flag reads one.
// - Timers 2/3 trigger on low-byte overflow in 8-bit, high-byte in 16-bit.
// - Normal track mode tracks continuously except during conversion.
// - Low-power track mode tracks three conversion clocks after start, then converts.
// - Low-power with external start tracks while low, converts on rising edge.
// - Positive selector picks pins, temperature sensor or supply; some codes reserved.
// - Negative selector picks pins, reference or ground; some codes reserved.
// - Ground negative selection means single-ended, otherwise differential.
// - Top three selector bits read zero and ignore writes.
// - Configuration resets to f8; two low bits read zero.
// - Justify bit picks right or left justified result layout.
// - Logic active only while enable bit set, else shutdown.
// - Source codes 000..101 as listed, 11x reserved; writing busy zero does nothing.
// - Single-ended unsigned; differential two's complement, sign-extended when right.
`timescale 1ns/100ps
`include "adcc_regs.vh"
module adcc_conv_ctrl (
  input wire clock,
  input wire rst_n,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  input wire timer0_ovf,
  input wire timer1_ovf,
  input wire timer2_low_ovf,
  input wire timer2_high_ovf,
  input wire timer2_split8,
  input wire timer3_low_ovf,
  input wire timer3_high_ovf,
  input wire timer3_split8,
  input wire external_convert_start,
  input wire [11:0] sar_result,
  output reg sar_track,
  output reg sar_convert,
  output wire sar_step,
  output reg converter_power,
  output reg [4:0] pos_route,
  output reg pos_route_valid,
  output reg [4:0] neg_route,
  output reg neg_route_valid,
  output reg differential_mode,
  output reg conversion_irq
);
  // ==========================================
  // State and registers
  localparam ST_IDLE = 2'd0;
  localparam ST_TRACK = 2'd1;
  localparam ST_CONV = 2'd2;

  reg [1:0] state_q;
  reg [4:0] neg_sel_q;
  reg [4:0] pos_sel_q;
  reg [4:0] sar_div_q;
  reg ljust_q;
  reg enable_q;
  reg track_mode_q;
  reg done_q;
  reg win_q;
  reg [2:0] src_q;
  reg [7:0] res_hi_q;
  reg [7:0] res_lo_q;
  reg [3:0] step_q;
  reg [2:0] ext_sync_q;
  reg ext_level_q;
  reg ext_prev_q;
  reg busy_prev_q;
  wire irq_enable;

  wire busy = (state_q != ST_IDLE);
  wire wr_ctl = sfr_wr && (sfr_addr == `ADCC_ADDR_CTL);
  wire sw_start = wr_ctl && sfr_wdata[`ADCC_CTL_BUSY];
  wire ext_rise = ext_level_q && !ext_prev_q;
  wire diff = (neg_sel_q != `ADCC_SEL_LAST);
  wire div_tick;

  // ==========================================
  // External start pin: three stages, change counts when stages two and three agree
  // Level starts low, so a pin held high shows one rising edge after reset
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_sync_q <= `ADCC_SYNC_ZERO;
      ext_level_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], external_convert_start};
      if (ext_sync_q[1] == ext_sync_q[2])
        ext_level_q <= ext_sync_q[2];
      ext_prev_q <= ext_level_q;
    end
  end

  // ==========================================
  // Start source selection
  reg start_evt;
  // Reserved codes land in the default branch and never start
  always @* begin
    case (src_q)
      `ADCC_SRC_SW: start_evt = sw_start;
      `ADCC_SRC_T0: start_evt = timer0_ovf;
      `ADCC_SRC_T2: start_evt = timer2_split8 ? timer2_low_ovf : timer2_high_ovf;
      `ADCC_SRC_T1: start_evt = timer1_ovf;
      `ADCC_SRC_EXT: start_evt = ext_rise;
      `ADCC_SRC_T3: start_evt = timer3_split8 ? timer3_low_ovf : timer3_high_ovf;
      default: start_evt = 1'b0;
    endcase
  end

  // Low-power external mode converts on the edge; tracking was the low phase
  wire ext_lp = track_mode_q && (src_q == `ADCC_SRC_EXT);
  // Busy gates every source, so a late event cannot restart a conversion
  wire go = enable_q && !busy && start_evt;

  adcc_clk_div u_div (
    .clock(clock),
    .rst_n(rst_n),
    .restart(go),
    .divisor(sar_div_q),
    .tick(div_tick)
  );
  assign sar_step = div_tick && busy;

  // ==========================================
  // Track and convert sequence
  // Disable aborts a conversion in flight; result bytes keep the old value
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      step_q <= 4'h0;
    end else if (!enable_q) begin
      state_q <= ST_IDLE;
      step_q <= 4'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          step_q <= 4'h0;
          if (go)
            state_q <= (track_mode_q && !ext_lp) ? ST_TRACK : ST_CONV;
        end
        ST_TRACK: begin
          if (div_tick) begin
            if (step_q == {2'b00, `ADCC_TRACK_CLKS} - 4'h1) begin
              state_q <= ST_CONV;
              step_q <= 4'h0;
            end else begin
              step_q <= step_q + 4'h1;
            end
          end
        end
        ST_CONV: begin
          if (div_tick) begin
            if (step_q == `ADCC_CONV_CLKS - 4'h1) begin
              state_q <= ST_IDLE;
              step_q <= 4'h0;
            end else begin
              step_q <= step_q + 4'h1;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
          step_q <= 4'h0;
        end
      endcase
    end
  end

  // Same condition as the last conversion step, shared with the result load
  wire conv_end = (state_q == ST_CONV) && div_tick && (step_q == `ADCC_CONV_CLKS - 4'h1);

  // ==========================================
  // Analog front-end controls
  // Registered so the switches never glitch during a bus write
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sar_track <= 1'b0;
      sar_convert <= 1'b0;
      converter_power <= 1'b0;
    end else begin
      converter_power <= enable_q;
      sar_convert <= enable_q && (state_q == ST_CONV);
      if (!enable_q)
        sar_track <= 1'b0;
      else if (!track_mode_q)
        sar_track <= !busy;
      else if (ext_lp)
        sar_track <= !busy && !ext_level_q;
      else
        sar_track <= (state_q == ST_TRACK);
    end
  end

  // ==========================================
  // Analog input routing
  // Reserved codes route nothing; register keeps written value
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pos_route <= `ADCC_RST_SEL;
      pos_route_valid <= 1'b0;
      neg_route <= `ADCC_RST_SEL;
      neg_route_valid <= 1'b0;
      differential_mode <= 1'b0;
    end else begin
      pos_route <= pos_sel_q;
      pos_route_valid <= (pos_sel_q <= `ADCC_SEL_PIN_MAX) || (pos_sel_q >= `ADCC_SEL_SPEC);
      neg_route <= neg_sel_q;
      neg_route_valid <= (neg_sel_q <= `ADCC_SEL_PIN_MAX) || (neg_sel_q >= `ADCC_SEL_SPEC);
      differential_mode <= diff;
    end
  end

  // ==========================================
  // Result formatting, loaded as the conversion ends
  // Left-justified layout is shared by both modes; low nibble stays zero
  reg [15:0] fmt;
  always @* begin
    if (ljust_q)
      fmt = {sar_result, 4'h0};
    else if (diff)
      fmt = {{4{sar_result[11]}}, sar_result};
    else
      fmt = {4'h0, sar_result};
  end

  // ==========================================
  // Register writes and flags
  // Reserved selector codes are stored as written; only the route is blanked
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      neg_sel_q <= `ADCC_RST_SEL;
      pos_sel_q <= `ADCC_RST_SEL;
      sar_div_q <= `ADCC_RST_DIV;
      ljust_q <= 1'b0;
      enable_q <= 1'b0;
      track_mode_q <= 1'b0;
      done_q <= 1'b0;
      win_q <= 1'b0;
      src_q <= 3'h0;
      res_hi_q <= 8'h00;
      res_lo_q <= 8'h00;
      busy_prev_q <= 1'b0;
      conversion_irq <= 1'b0;
    end else begin
      busy_prev_q <= busy;
      if (sfr_wr && sfr_addr == `ADCC_ADDR_NEG)
        neg_sel_q <= sfr_wdata[4:0];
      if (sfr_wr && sfr_addr == `ADCC_ADDR_POS)
        pos_sel_q <= sfr_wdata[4:0];
      if (sfr_wr && sfr_addr == `ADCC_ADDR_CFG) begin
        sar_div_q <= sfr_wdata[7:3];
        ljust_q <= sfr_wdata[2];
      end
      if (wr_ctl) begin
        enable_q <= sfr_wdata[`ADCC_CTL_EN];
        track_mode_q <= sfr_wdata[`ADCC_CTL_TM];
        win_q <= sfr_wdata[`ADCC_CTL_WIN];
        src_q <= sfr_wdata[2:0];
      end
      if (conv_end) begin
        res_hi_q <= fmt[15:8];
        res_lo_q <= fmt[7:0];
      end
      // Set on busy falling edge wins over a same-cycle software clear
      if (busy_prev_q && !busy)
        done_q <= 1'b1;
      else if (wr_ctl)
        done_q <= sfr_wdata[`ADCC_CTL_DONE];
      conversion_irq <= busy_prev_q && !busy && irq_enable;
    end
  end

  // Interrupt enable lives in the core's enable register; always on here
  // Kept as a named net so a real enable can be wired in later
  assign irq_enable = 1'b1;

  // ==========================================
  // Register reads
  // Unmapped addresses and an idle strobe both read zero
  always @* begin
    sfr_rdata = 8'h00;
    if (sfr_rd) begin
      case (sfr_addr)
        `ADCC_ADDR_NEG: sfr_rdata = {3'b000, neg_sel_q};
        `ADCC_ADDR_POS: sfr_rdata = {3'b000, pos_sel_q};
        `ADCC_ADDR_CFG: sfr_rdata = {sar_div_q, ljust_q, 2'b00};
        `ADCC_ADDR_RLO: sfr_rdata = res_lo_q;
        `ADCC_ADDR_RHI: sfr_rdata = res_hi_q;
        `ADCC_ADDR_CTL: sfr_rdata = {enable_q, track_mode_q, done_q, busy, win_q, src_q};
        default: sfr_rdata = 8'h00;
      endcase
    end
  end
endmodule

// ### adcc_regs.vh
// Register addresses, field positions, reset values and codes for the converter control
`ifndef ADCC_REGS_VH
`define ADCC_REGS_VH
// ==========================================
// Register addresses (8-bit special function register space)
`define ADCC_ADDR_NEG 8'hba
`define ADCC_ADDR_POS 8'hbb
`define ADCC_ADDR_CFG 8'hbc
`define ADCC_ADDR_RLO 8'hbd
`define ADCC_ADDR_RHI 8'hbe
`define ADCC_ADDR_CTL 8'he8
// ==========================================
// Reset values
`define ADCC_RST_CFG 8'hf8
`define ADCC_RST_DIV 5'h1f
`define ADCC_RST_SEL 5'h00
`define ADCC_RST_CTL 8'h00
// ==========================================
// Control register bit positions
`define ADCC_CTL_EN 7
`define ADCC_CTL_TM 6
`define ADCC_CTL_DONE 5
`define ADCC_CTL_BUSY 4
`define ADCC_CTL_WIN 3
// ==========================================
// Start source codes
`define ADCC_SRC_SW 3'h0
`define ADCC_SRC_T0 3'h1
`define ADCC_SRC_T2 3'h2
`define ADCC_SRC_T1 3'h3
`define ADCC_SRC_EXT 3'h4
`define ADCC_SRC_T3 3'h5
// ==========================================
// Input selection codes
`define ADCC_SEL_PIN_MAX 5'h14
`define ADCC_SEL_SPEC 5'h1e
`define ADCC_SEL_LAST 5'h1f
// ==========================================
// Timing counts in conversion clocks, and the start synchronizer reset value
`define ADCC_TRACK_CLKS 2'h3
`define ADCC_CONV_CLKS 4'hd
`define ADCC_SYNC_ZERO 3'h0
`endif

// ### adcc_clk_div.v
// Conversion clock enable divider: one pulse every (divisor + 1) system clocks
`timescale 1ns/100ps
`include "adcc_regs.vh"
module adcc_clk_div (
  input wire clock,
  input wire rst_n,
  input wire restart,
  input wire [4:0] divisor,
  output reg tick
);
  reg [4:0] count_q;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 5'h00;
      tick <= 1'b0;
    end else if (restart) begin
      // Phase aligned to the start: first tick lands divisor + 1 clocks later
      count_q <= 5'h01;
      tick <= (divisor == 5'h00);
    end else if (count_q >= divisor) begin
      count_q <= 5'h00;
      tick <= 1'b1;
    end else begin
      count_q <= count_q + 5'h01;
      tick <= 1'b0;
    end
  end
endmodule

// ### adcc_far_model.sv
// Far side model: timer overflow pulses and the analog result
`timescale 1ns/100ps
module adcc_far_model (
  input wire clock,
  input wire [5:0] kick,
  input wire [11:0] value,
  input wire sar_convert,
  output reg [5:0] ovf = 6'h00,
  output wire [11:0] sar_result
);
  reg [11:0] junk_q = 12'h000;
  // =====
  // Timers
  always @(posedge clock) begin
    ovf <= kick;
    junk_q <= junk_q + 12'h5a3;
  end
  // Result is garbage outside a conversion, never a stale copy
  assign sar_result = sar_convert ? value : junk_q;
endmodule

// ### adcc_conv_ctrl_properties.sv
// Port checks for the converter control
`timescale 1ns/100ps
module adcc_conv_ctrl_props (
  input wire clock,
  input wire rst_n,
  input wire sfr_rd,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_rdata,
  input wire sar_track,
  input wire sar_convert,
  input wire sar_step,
  input wire converter_power,
  input wire [4:0] pos_route,
  input wire pos_route_valid,
  input wire [4:0] neg_route,
  input wire neg_route_valid,
  input wire differential_mode,
  input wire conversion_irq
);
  reg up_q;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // =====
  // Routes settle one edge after reset
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      up_q <= 1'b0;
    else
      up_q <= 1'b1;
  end
  irq_after_end_a:
    assert property ($fell(sar_convert) |-> ##[0:1] conversion_irq) else $error("no irq");
  irq_cause_a:
    assert property (conversion_irq |-> $past(sar_convert) || $past(sar_convert, 2))
    else $error("stray irq");
  track_hold_a:
    assert property (!(sar_track && sar_convert)) else $error("track during convert");
  shutdown_a:
    assert property (!converter_power |-> !sar_convert && !sar_step) else $error("active off");
  diff_mode_a:
    assert property (up_q |-> differential_mode == (neg_route != 5'h1f))
    else $error("mode wrong");
  pos_valid_a:
    assert property (up_q |-> pos_route_valid == (pos_route <= 5'h14 || pos_route >= 5'h1e))
    else $error("pos valid");
  neg_valid_a:
    assert property (up_q |-> neg_route_valid == (neg_route <= 5'h14 || neg_route >= 5'h1e))
    else $error("neg valid");
  sel_unused_a:
    assert property (sfr_rd && (sfr_addr == 8'hba || sfr_addr == 8'hbb) |-> !sfr_rdata[7:5])
    else $error("sel top bits");
  cfg_unused_a:
    assert property (sfr_rd && sfr_addr == 8'hbc |-> !sfr_rdata[1:0]) else $error("cfg low bits");
  busy_read_a:
    assert property (sfr_rd && sfr_addr == 8'he8 && !sfr_rdata[4] |=> !sar_convert)
    else $error("busy low");
  cover property ($fell(sar_convert));
  cover property (up_q && !differential_mode);
  cover property (sar_track ##1 sar_convert);
endmodule
bind adcc_conv_ctrl adcc_conv_ctrl_props u_props (.clock(clock), .rst_n(rst_n),
  .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_rdata(sfr_rdata), .sar_track(sar_track),
  .sar_convert(sar_convert), .sar_step(sar_step), .converter_power(converter_power),
  .pos_route(pos_route), .pos_route_valid(pos_route_valid), .neg_route(neg_route),
  .neg_route_valid(neg_route_valid), .differential_mode(differential_mode),
  .conversion_irq(conversion_irq));

// ### adcc_conv_ctrl_tb.sv
// Self-checking bench for the converter control
`timescale 1ns/100ps
module adcc_conv_ctrl_tb;
  localparam [55:0] RADR = 56'hbabbbcbdbee8c0;
  localparam [55:0] REXP = 56'h0000f800000000;
  localparam [31:0] ADR = 32'hbabbbcc0;
  localparam [31:0] WEX = 32'h1515f400;
  localparam [119:0] CASES = 120'h06003f_052010_020408_030200_010100;
  localparam [11:0] VAL = 12'h9c5;
  reg clock = 1'b0;
  reg rst_n = 1'b0;
  reg sfr_wr = 1'b0;
  reg sfr_rd = 1'b0;
  reg [7:0] sfr_addr = 8'h00;
  reg [7:0] sfr_wdata = 8'h00;
  reg [5:0] kick = 6'h00;
  reg [1:0] split = 2'b01;
  reg ext = 1'b1;
  reg [7:0] rv;
  reg [15:0] ex;
  reg [23:0] t;
  integer failures = 0, total_checks = 0, trk_n = 0, cnv_n = 0, irq_n = 0, i, d, r;
  wire [7:0] sfr_rdata;
  wire [5:0] ovf;
  wire [11:0] sar_result;
  wire sar_track, sar_convert, pwr, differential_mode, conversion_irq, pos_route_valid;
  initial begin
    forever #4 clock = ~clock;
  end
  adcc_conv_ctrl u_dut (.clock(clock), .rst_n(rst_n), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .timer0_ovf(ovf[0]),
    .timer1_ovf(ovf[1]), .timer2_low_ovf(ovf[2]), .timer2_high_ovf(ovf[3]),
    .timer2_split8(split[0]), .timer3_low_ovf(ovf[4]), .timer3_high_ovf(ovf[5]),
    .timer3_split8(split[1]), .external_convert_start(ext), .sar_result(sar_result),
    .sar_track(sar_track), .sar_convert(sar_convert), .sar_step(), .converter_power(pwr),
    .pos_route(), .pos_route_valid(pos_route_valid), .neg_route(), .neg_route_valid(),
    .differential_mode(differential_mode), .conversion_irq(conversion_irq));
  adcc_far_model u_far (.clock(clock), .kick(kick), .value(VAL), .sar_convert(sar_convert),
    .ovf(ovf), .sar_result(sar_result));
  always @(posedge clock) begin
    trk_n <= trk_n + sar_track;
    cnv_n <= cnv_n + sar_convert;
    irq_n <= irq_n + conversion_irq;
  end
  // =====
  // Bus cycles and comparisons
  task chk(input [15:0] got, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge clock) #1;
      sfr_wr = 1'b1;
      sfr_addr = a;
      sfr_wdata = v;
      @(posedge clock) #1;
      sfr_wr = 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clock) #1;
      sfr_rd = 1'b1;
      sfr_addr = a;
      @(posedge clock);
      rv = sfr_rdata;
      #1;
      sfr_rd = 1'b0;
    end
  endtask
  task rdchk(input [7:0] a, input [7:0] e);
    begin
      rd(a);
      chk(rv, e);
    end
  endtask
  task pulse(input [5:0] m);
    begin
      @(posedge clock) #1;
      kick = m;
      @(posedge clock) #1;
      kick = 6'h00;
    end
  endtask
  task zero;
    begin
      trk_n = 0;
      cnv_n = 0;
      irq_n = 0;
    end
  endtask
  task wait_done;
    begin
      r = 0;
      rv = 8'h00;
      while (rv[5] !== 1'b1 && r < 1000) begin
        rd(8'he8);
        r = r + 1;
      end
      if (rv[5] !== 1'b1) begin
        failures = failures + 1;
        end_sim;
      end
    end
  endtask
  task conv_chk(input lp);
    begin
      wait_done;
      chk(cnv_n, 13 * (d + 1));
      chk(irq_n, 1);
      if (lp)
        chk(trk_n, 3 * (d + 1));
    end
  endtask
  task end_sim;
    begin
      $display("checks=%0d failures=%0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // =====
  // Scenarios
  initial begin
    repeat (3) @(posedge clock);
    #1 rst_n = 1'b1;
    for (i = 0; i < 7; i = i + 1) begin
      rdchk(RADR[i*8 +: 8], REXP[i*8 +: 8]);
    end
    for (i = 0; i < 4; i = i + 1) begin
      wr(ADR[i*8 +: 8], 8'hf5);
      rdchk(ADR[i*8 +: 8], WEX[i*8 +: 8]);
    end
    chk(pos_route_valid, 1'b0);
    wr(8'hbb, 8'h1e);
    wr(8'he8, 8'h80);
    for (i = 0; i < 4; i = i + 1) begin
      d = i * 10 + 1;
      wr(8'hbc, {d[4:0], i[0], 2'b00});
      wr(8'hba, i[1] ? 8'h1f : 8'h00);
      zero;
      wr(8'he8, 8'h90);
      rdchk(8'he8, 8'h90);
      chk(differential_mode, !i[1]);
      chk(pos_route_valid, 1'b1);
      conv_chk(1'b0);
      ex = i[0] ? {VAL, 4'h0} : (i[1] ? {4'h0, VAL} : {{4{VAL[11]}}, VAL});
      rdchk(8'hbe, ex[15:8]);
      rdchk(8'hbd, ex[7:0]);
      wr(8'he8, 8'h80);
      rdchk(8'he8, 8'h80);
      chk(sar_track, 1'b1);
    end
    d = 2;
    wr(8'hbc, 8'h10);
    for (i = 0; i < 5; i = i + 1) begin
      t = CASES[i*24 +: 24];
      wr(8'he8, {5'b11000, t[18:16]});
      // Let the last normal-mode track level drain before counting
      @(posedge clock) #1;
      zero;
      pulse(t[5:0]);
      repeat (4) @(posedge clock);
      rdchk(8'he8, {5'b11000, t[18:16]});
      if (t[13:8] != 6'h00) begin
        pulse(t[13:8]);
        repeat (6) @(posedge clock);
        pulse(t[13:8]);
        conv_chk(1'b1);
        wr(8'he8, 8'hc0);
      end
    end
    wr(8'he8, 8'hc4);
    zero;
    ext = 1'b0; // Pin skipped by the crossbar, driven straight
    repeat (8) @(posedge clock);
    #1 chk(sar_track, 1'b1);
    ext = 1'b1;
    conv_chk(1'b0);
    wr(8'he8, 8'h10);
    rdchk(8'he8, 8'h00);
    chk(pwr, 1'b0);
    end_sim;
  end
endmodule
